// ---- hdl/psram_port_defs.svh ----
// Constants for the synchronous burst port of the pseudo-static RAM die
`ifndef PSRAM_PORT_DEFS_SVH
`define PSRAM_PORT_DEFS_SVH

// ****************************************
// Array geometry
// ****************************************
`define PP_DATA_W        16
`define PP_ADDR_W        4
`define PP_DEPTH         16
`define PP_CNT_W         4

// ****************************************
// Reset values and latency floor of the configuration
// ****************************************
`define PP_LATENCY_RST   4'h5
`define PP_BURST_LEN_RST 4'h4
`define PP_LATENCY_MIN   4'h2

// ****************************************
// Far-end timing, in ns, with cycle counts at the 4 ns system clock
// ****************************************
`define PP_MCLK_PERIOD_NS        4
`define PP_BURST_END_GAP_NS      7
`define PP_BURST_END_GAP_CYC     \
  ((`PP_BURST_END_GAP_NS + `PP_MCLK_PERIOD_NS - 1) / `PP_MCLK_PERIOD_NS)
`define PP_BURST_CYCLE_LIMIT_NS  2500
`define PP_BURST_CYCLE_LIMIT_CYC (`PP_BURST_CYCLE_LIMIT_NS / `PP_MCLK_PERIOD_NS)

`endif

// ---- hdl/psram_port_pkg.sv ----
// Types shared by the burst port design
package psram_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT  = 2'b01,
    ST_XFER = 2'b10,
    ST_HOLD = 2'b11
  } link_state_t;

  typedef struct packed {
    logic cs_n;
    logic addr_valid_n;
    logic we_n;
    logic oe_n;
    logic upper_byte_en_n;
    logic lower_byte_en_n;
    logic reg_set_sel_n;
  } pin_ctrl_t;

  typedef struct packed {
    logic [3:0] latency;
    logic [3:0] burst_len;
  } burst_cfg_t;

endpackage

// ---- hdl/psram_sync2.sv ----
// Two-stage synchroniser for levels and quasi-static words
`timescale 1ns/1ps
module psram_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

// ---- hdl/psram_sync_burst_port.sv ----
// Synchronous burst read/write port of the pseudo-static RAM die
//
// Functional notes
// - Wait indicator driven low at the first edge with chip select and address strobe both low (high at once for latency 2).
// - Wait indicator driven high on the edge one before latency count.
// - Wait indicator released to high impedance at the first link edge that sees chip select high.
// - Burst starts from the first rising edge with address strobe low.
// - Beats written with both byte enables high leave the word unwritten.
// - Stopped clock suspends read output; suspended word comes out first.
`timescale 1ns/1ps
`include "psram_port_defs.svh"
module psram_sync_burst_port
  import psram_port_pkg::*;
(
  // System side
  input  wire logic                     i_mclk,
  input  wire logic                     i_rstn,
  input  wire logic [3:0]               i_latency,
  input  wire logic [3:0]               i_burst_len,
  output logic                          o_link_busy,
  output logic [7:0]                    o_burst_count,
  // Link pins, clocked by the controller
  input  wire logic                     i_link_clk,
  input  wire pin_ctrl_t                i_ctrl,
  input  wire logic [`PP_ADDR_W-1:0]    i_addr,
  input  wire logic [`PP_DATA_W-1:0]    i_dq,
  output logic      [`PP_DATA_W-1:0]    o_dq,
  output logic      [1:0]               o_dq_oe,
  output logic                          o_wait_n,
  output logic                          o_wait_oe
);

  // ****************************************
  // Configuration crossing into the link domain
  // ****************************************
  burst_cfg_t cfg_sys;
  burst_cfg_t next_cfg_sys;
  burst_cfg_t cfg_link;

  // Configuration is quasi-static: change it only while no burst runs
  always_comb begin
    next_cfg_sys.latency   = (i_latency < `PP_LATENCY_MIN) ? `PP_LATENCY_MIN : i_latency;
    next_cfg_sys.burst_len = (i_burst_len == 4'h0) ? 4'h1 : i_burst_len;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_sys <= '{latency: `PP_LATENCY_RST, burst_len: `PP_BURST_LEN_RST};
    end else begin
      cfg_sys <= next_cfg_sys;
    end
  end

  psram_sync2 #(.W(8)) u_cfg_sync (
    .i_clk  (i_link_clk),
    .i_rstn (i_rstn),
    .i_d    (cfg_sys),
    .o_q    (cfg_link)
  );

  // ****************************************
  // Link-domain burst engine
  // ****************************************
  link_state_t              state;
  link_state_t              next_state;
  logic [`PP_CNT_W-1:0]     cnt;
  logic [`PP_CNT_W-1:0]     next_cnt;
  logic [`PP_CNT_W-1:0]     beat;
  logic [`PP_CNT_W-1:0]     next_beat;
  logic [`PP_ADDR_W-1:0]    addr;
  logic [`PP_ADDR_W-1:0]    next_addr;
  logic                     is_wr;
  logic                     next_is_wr;
  logic                     adv_seen;
  logic                     next_adv_seen;
  logic [`PP_DATA_W-1:0]    next_dq;
  logic [1:0]               next_dq_oe;
  logic                     next_wait_n;
  logic                     next_wait_oe;
  logic                     done_tgl;
  logic                     next_done_tgl;
  logic [`PP_DATA_W-1:0]    mem [`PP_DEPTH];
  logic [`PP_DATA_W-1:0]    next_word;
  logic                     mem_we;
  logic                     start;
  logic                     rd_drive;

  // Merge a beat into a stored word under the byte enables
  function automatic logic [`PP_DATA_W-1:0] merge_bytes(
    input logic [`PP_DATA_W-1:0] old_w,
    input logic [`PP_DATA_W-1:0] new_w,
    input logic                  ub_n,
    input logic                  lb_n
  );
    logic [`PP_DATA_W-1:0] r;
    r = old_w;
    if (!ub_n) begin
      r[15:8] = new_w[15:8];
    end
    if (!lb_n) begin
      r[7:0] = new_w[7:0];
    end
    return r;
  endfunction

  // Mode-register cycles (select pin low) are not bursts and are ignored here
  assign start = !i_ctrl.cs_n && !i_ctrl.addr_valid_n && !adv_seen
                 && i_ctrl.reg_set_sel_n
                 && (state == ST_IDLE || state == ST_HOLD);

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_beat     = beat;
    next_addr     = addr;
    next_is_wr    = is_wr;
    next_dq       = o_dq;
    next_wait_n   = o_wait_n;
    next_wait_oe  = o_wait_oe;
    next_done_tgl = done_tgl;
    next_word     = mem[addr];
    mem_we        = 1'b0;
    rd_drive      = 1'b0;
    // Only the first edge of a low strobe counts; held-low edges are ignored
    next_adv_seen = !i_ctrl.cs_n && !i_ctrl.addr_valid_n;
    if (i_ctrl.cs_n) begin
      // Deselect ends any burst; the pin is only seen at a link edge
      next_state   = ST_IDLE;
      next_wait_oe = 1'b0;
      next_wait_n  = 1'b1;
    end else if (start) begin
      next_addr    = i_addr;
      next_is_wr   = i_ctrl.oe_n && !i_ctrl.we_n;
      next_cnt     = 4'h1;
      next_beat    = 4'h0;
      next_wait_oe = 1'b1;
      next_wait_n  = 1'b0;
      next_dq      = mem[i_addr];
      next_state   = ST_LAT;
      if (cfg_link.latency == `PP_LATENCY_MIN) begin
        next_wait_n = 1'b1;
        next_state  = ST_XFER;
      end
    end else begin
      next_wait_oe = 1'b1;
      case (state)
        ST_LAT: begin
          next_cnt = cnt + 4'h1;
          if (next_cnt == cfg_link.latency - 4'h1) begin
            next_wait_n = 1'b1;
            next_state  = ST_XFER;
          end
        end
        ST_XFER: begin
          // One beat per edge; a halted clock simply freezes this point
          if (is_wr) begin
            next_word = merge_bytes(mem[addr], i_dq, i_ctrl.upper_byte_en_n,
                                    i_ctrl.lower_byte_en_n);
            mem_we    = 1'b1;
          end
          next_beat = beat + 4'h1;
          if (next_beat == cfg_link.burst_len) begin
            next_state    = ST_HOLD;
            next_done_tgl = !done_tgl;
          end else begin
            next_addr = addr + 4'h1;
            next_dq   = mem[next_addr];
          end
        end
        ST_HOLD: begin
          next_state = ST_HOLD;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    rd_drive   = !next_is_wr && !i_ctrl.cs_n && !i_ctrl.oe_n
                 && (next_state == ST_XFER || next_state == ST_HOLD);
    next_dq_oe = rd_drive ? {!i_ctrl.upper_byte_en_n, !i_ctrl.lower_byte_en_n} : 2'b00;
  end

  // Reset is taken asynchronously in both domains; assume no link edges near release
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      beat      <= '0;
      addr      <= '0;
      is_wr     <= 1'b0;
      adv_seen  <= 1'b0;
      o_dq      <= '0;
      o_dq_oe   <= 2'b00;
      o_wait_n  <= 1'b1;
      o_wait_oe <= 1'b0;
      done_tgl  <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      beat      <= next_beat;
      addr      <= next_addr;
      is_wr     <= next_is_wr;
      adv_seen  <= next_adv_seen;
      o_dq      <= next_dq;
      o_dq_oe   <= next_dq_oe;
      o_wait_n  <= next_wait_n;
      o_wait_oe <= next_wait_oe;
      done_tgl  <= next_done_tgl;
    end
  end

  // Array has no reset: contents are undefined after power-up, as in a real die
  always_ff @(posedge i_link_clk) begin
    if (mem_we) begin
      mem[addr] <= next_word;
    end
  end

  // ****************************************
  // Status crossing back to the system domain
  // ****************************************
  logic [1:0] link_stat;
  logic [1:0] stat_sys;
  logic       done_prev;
  logic       next_done_prev;
  logic       next_busy;
  logic [7:0] next_count;

  assign link_stat = {done_tgl, state != ST_IDLE};

  psram_sync2 #(.W(2)) u_stat_sync (
    .i_clk  (i_mclk),
    .i_rstn (i_rstn),
    .i_d    (link_stat),
    .o_q    (stat_sys)
  );

  always_comb begin
    next_busy      = stat_sys[0];
    next_done_prev = stat_sys[1];
    next_count     = o_burst_count;
    if (stat_sys[1] != done_prev) begin
      next_count = o_burst_count + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_link_busy   <= 1'b0;
      done_prev     <= 1'b0;
      o_burst_count <= 8'h00;
    end else begin
      o_link_busy   <= next_busy;
      done_prev     <= next_done_prev;
      o_burst_count <= next_count;
    end
  end

endmodule

// ---- bench/psram_port_sva.sv ----
// Link-side assertions for the burst port
`timescale 1ns/1ps
module psram_port_sva
  import psram_port_pkg::*;
(
  // Watched ports
  input wire logic        i_rstn,
  input wire logic        i_link_clk,
  input wire logic [3:0]  i_latency,
  input wire logic [3:0]  i_burst_len,
  input wire pin_ctrl_t   i_ctrl,
  input wire logic [15:0] o_dq,
  input wire logic [1:0]  o_dq_oe,
  input wire logic        o_wait_n,
  input wire logic        o_wait_oe
);
  logic       sel, start, cfg, prev_sel, next_prev_sel;
  logic [3:0] cnt, next_cnt;
  assign sel = !i_ctrl.cs_n && !i_ctrl.addr_valid_n;
  assign start = sel && i_ctrl.reg_set_sel_n && !prev_sel && (!o_wait_oe || o_wait_n);
  assign cfg = i_latency == 4'h5 && i_burst_len == 4'h4;
  // Edges since start, saturating so a long hold never wraps into the beats
  always_comb begin
    next_prev_sel = sel;
    next_cnt = cnt + {3'h0, cnt != 4'h0 && cnt != 4'hF};
    if (start)
      next_cnt = 4'h1;
    if (i_ctrl.cs_n)
      next_cnt = 4'h0;
  end
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_sel <= 1'b0;
      cnt <= 4'h0;
    end else begin
      prev_sel <= next_prev_sel;
      cnt <= next_cnt;
    end
  end
  default clocking @(posedge i_link_clk); endclocking
  default disable iff (!i_rstn);
  wait_low_a: assert property (start |=> o_wait_oe && !o_wait_n)
    else $error("wait low");
  wait_high_a: assert property (start && cfg |=> (!o_wait_n)[*3] ##1 o_wait_n)
    else $error("wait high");
  wait_rel_a: assert property (i_ctrl.cs_n |=> !o_wait_oe)
    else $error("wait release");
  held_adv_a: assert property (sel && prev_sel && o_wait_oe && o_wait_n |=> o_wait_n)
    else $error("held strobe");
  dq_off_a: assert property (i_ctrl.cs_n || i_ctrl.oe_n || !i_ctrl.we_n |=> !o_dq_oe)
    else $error("dq drive");
  byte_lane_a: assert property (o_dq_oe != 2'b00 |->
    o_dq_oe == ~$past({i_ctrl.upper_byte_en_n, i_ctrl.lower_byte_en_n}))
    else $error("byte lanes");
  lat_data_a: assert property (cfg && cnt inside {[1:3]} && i_ctrl.we_n && !start
    |=> $stable(o_dq))
    else $error("early beat");
  hold_data_a: assert property (cfg && cnt >= 4'h8 && i_ctrl.we_n && !i_ctrl.cs_n
    && !start |=> $stable(o_dq))
    else $error("last word");
  cover property (start && !i_ctrl.we_n);
  cover property (start && i_ctrl.we_n);
  cover property (sel && prev_sel && o_wait_n);
endmodule

bind psram_sync_burst_port psram_port_sva u_sva (.i_rstn(i_rstn), .i_link_clk(i_link_clk),
  .i_latency(i_latency), .i_burst_len(i_burst_len), .i_ctrl(i_ctrl), .o_dq(o_dq),
  .o_dq_oe(o_dq_oe), .o_wait_n(o_wait_n), .o_wait_oe(o_wait_oe));

// ---- bench/psram_ctrl_model.sv ----
// Memory controller model that clocks and drives the link pins
`timescale 1ns/1ps
module psram_ctrl_model
  import psram_port_pkg::*;
(
  // Link pins
  output logic             o_lclk,
  output pin_ctrl_t        o_ctrl,
  output logic [3:0]       o_addr,
  output logic [15:0]      o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic [1:0]  i_rdata_oe
);
  logic [15:0] wd [4], got [4], smp;
  initial begin
    o_lclk = 1'b0;
    o_ctrl = 7'h7F;
    o_addr = 4'h0;
    o_wdata = 16'h0000;
  end
  // One link period; the clock only runs while step is called, with chip select high or low
  task automatic step(input pin_ctrl_t c, input logic [15:0] d, input logic [3:0] a);
    #62.5 o_lclk = 1'b1;
    // An undriven lane reads as the inverse of its last value, so a missing enable shows
    smp[15:8] = i_rdata_oe[1] ? i_rdata[15:8] : ~i_rdata[15:8];
    smp[7:0]  = i_rdata_oe[0] ? i_rdata[7:0] : ~i_rdata[7:0];
    o_ctrl <= c;
    o_wdata <= d;
    o_addr <= a;
    #62.5 o_lclk = 1'b0;
  endtask
  // Latency 5, four beats; pins set at edge j are seen at edge j+1
  task automatic burst(input logic wr, input logic [3:0] a, input int adv, input logic [3:0] skip,
    input int stall);
    pin_ctrl_t c;
    int k;
    for (int j = 0; j < 9; j++) begin
      k = j - 4;
      c = 7'h7F;
      c.cs_n = 1'b0;
      c.addr_valid_n = j >= adv;
      c.we_n = !wr;
      c.oe_n = wr;
      if (!(wr && k inside {[0:3]} && skip[k]))
        {c.upper_byte_en_n, c.lower_byte_en_n} = 2'b00;
      if (j == stall)
        #400;
      step(c, (wr && k inside {[0:3]}) ? wd[k] : ~o_wdata, a);
      if (j >= 5)
        got[j-5] = smp;
    end
  endtask
  task automatic stop();
    step(7'h7F, ~o_wdata, o_addr);
    step(7'h7F, ~o_wdata, o_addr);
  endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the burst port
`timescale 1ns/1ps
module testbench;
  import psram_port_pkg::*;
  logic        i_mclk, i_rstn, o_link_busy, i_link_clk, o_wait_n, o_wait_oe;
  logic [3:0]  i_latency, i_burst_len, i_addr;
  logic [7:0]  o_burst_count;
  pin_ctrl_t   i_ctrl;
  logic [15:0] i_dq, o_dq;
  logic [1:0]  o_dq_oe;
  logic [15:0] old [4];
  int          num_errors = 0;
  int          compares = 0;
  psram_sync_burst_port DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_latency(i_latency),
    .i_burst_len(i_burst_len), .o_link_busy(o_link_busy), .o_burst_count(o_burst_count),
    .i_link_clk(i_link_clk), .i_ctrl(i_ctrl), .i_addr(i_addr), .i_dq(i_dq), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .o_wait_n(o_wait_n), .o_wait_oe(o_wait_oe));
  psram_ctrl_model ctrl (.o_lclk(i_link_clk), .o_ctrl(i_ctrl), .o_addr(i_addr),
    .o_wdata(i_dq), .i_rdata(o_dq), .i_rdata_oe(o_dq_oe));
  always #2 i_mclk = ~i_mclk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    i_rstn = 1'b0;
    i_latency = 4'h5;
    i_burst_len = 4'h4;
    ctrl.step(7'h7F, 16'h0000, 4'h0);
    ctrl.step(7'h7F, 16'h0000, 4'h0);
    #10 @(posedge i_mclk) i_rstn <= 1'b1;
    repeat (3) ctrl.step(7'h7F, 16'h0000, 4'h0);
    chk(16'(o_wait_oe), 16'h0000);
    chk(16'(o_dq_oe), 16'h0000);
    // Strobe with the register-set pin low must not open a burst
    ctrl.step(7'h10, 16'h0000, 4'h3);
    ctrl.step(7'h7F, 16'h0000, 4'h3);
    chk(16'(o_wait_n), 16'h0001);
    $display("Test reset done");
    ctrl.wd = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    ctrl.burst(1'b1, 4'hE, 1, 4'h0, 99);
    old = ctrl.wd;
    ctrl.wd = '{16'hA0A0, 16'hB1B1, 16'hC2C2, 16'hD3D3};
    ctrl.burst(1'b1, 4'hE, 1, 4'h4, 99);
    chk(16'({o_wait_oe, o_wait_n}), 16'h0003);
    chk(16'(o_link_busy), 16'h0001);
    ctrl.stop();
    chk(16'(o_wait_oe), 16'h0000);
    $display("Test chained writes done");
    ctrl.burst(1'b0, 4'hE, 10, 4'h0, 6);
    chk(16'(o_dq_oe), 16'h0003);
    for (int k = 0; k < 4; k++)
      chk(ctrl.got[k], k == 2 ? old[2] : ctrl.wd[k]);
    chk(o_dq, ctrl.wd[3]);
    ctrl.stop();
    $display("Test held strobe read done");
    for (int n = 0; n < 40 && o_burst_count !== 8'h03; n++)
      @(posedge i_mclk);
    chk(16'(o_burst_count), 16'h0003);
    chk(16'(o_link_busy), 16'h0000);
    $display("Test system side done");
    close_out();
  end
endmodule
